// ---- logic/gcr_consts.svh ----
`ifndef GCR_CONSTS_SVH
`define GCR_CONSTS_SVH
`define GCR_OFFSET        8'hd0
`define GCR_RESET         32'h0000_0000
`define GCR_BIT_PAIR_SEL  25
`define GCR_BIT_HIDE      24
`define GCR_BIT_FPU_EN    13
`define GCR_BIT_KBD_LEN   12
`define GCR_WMASK         32'h0300_3000
`define GCR_PORT_FPU_CLR  16'h00f0
`define GCR_PORT_KBD_DATA 16'h0060
`endif

// ---- logic/gcr_general_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gcr_consts.svh"
// Function
// (R1) protocol bit set: fifth req/gnt pair works as pc/pci pair b.
// (R2) protocol bit clear: fifth pair is a standard pci request/grant pair.
// (R3) gpio use-select set overrides the pair to general-purpose in/out.
// (R4) hide bit set: ad22 kept low in config cycles to legacy bridge.
// (R5) enabled fpu error low raises irq13, held until port f0h write.
// (R6) same condition drives ignore-numeric-error output active.
// (R7) enable clear: fpu error creates neither irq13 nor ignore-numeric-error.
// (R8) latch enable set: irq1 active edge held until port 60h read.
// (R9) latch enable clear: irq1 passes straight through unlatched.
// (R10) reserved bits read zero, ignore writes; implemented bits reset cleared.
module gcr_general_control
(
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire logic                      cfg_wr,
  input  wire logic                      cfg_rd,
  input  wire logic [7:0]                cfg_addr,
  input  wire logic [3:0]                cfg_be,
  input  wire logic [31:0]               cfg_wdata,
  output logic      [31:0]               cfg_rdata,
  input  wire logic                      io_wr,
  input  wire logic                      io_rd,
  input  wire logic [15:0]               io_addr,
  input  wire logic                      pair_gpio_use,
  input  wire logic                      cfg_cycle_to_bridge,
  input  wire logic                      ad22_req,
  output logic                           ad22_drive,
  output gcr_pkg::gcr_pair_mode_type     pair_mode,
  input  wire logic                      fpu_error_in_n,
  input  wire logic                      irq1_in,
  output logic                           irq13,
  output logic                           ignore_numeric_error_n,
  output logic                           irq1_out
);
  // ==========================================================
  // register
  logic [31:0] gc_r;
  logic [31:0] gc_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  function automatic logic gc_hit(input logic [7:0] a);
    return a == `GCR_OFFSET;
  endfunction

  always_comb
  begin
    gc_nxt    = gc_r;
    rdata_nxt = rdata_r;
    if (cfg_wr && gc_hit(cfg_addr))
    begin
      for (int b = 0; b < 4; b++)
        if (cfg_be[b])
          gc_nxt[8*b +: 8] = cfg_wdata[8*b +: 8];
      gc_nxt = gc_nxt & `GCR_WMASK; // see (R10)
    end
    if (cfg_rd)
      rdata_nxt = gc_hit(cfg_addr) ? (gc_r & `GCR_WMASK) : 32'h0000_0000; // see (R10)
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      gc_r    <= `GCR_RESET; // see (R10)
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      gc_r    <= gc_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign cfg_rdata = rdata_r;

  // ==========================================================
  // pin synchronisers
  logic fe_s1_r;
  logic fe_s2_r;
  logic i1_s1_r;
  logic i1_s2_r;
  logic gp_s1_r;
  logic gp_s2_r;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      fe_s1_r <= 1'b1;
      fe_s2_r <= 1'b1;
      i1_s1_r <= 1'b0;
      i1_s2_r <= 1'b0;
      gp_s1_r <= 1'b0;
      gp_s2_r <= 1'b0;
    end
    else
    begin
      fe_s1_r <= fpu_error_in_n;
      fe_s2_r <= fe_s1_r;
      i1_s1_r <= irq1_in;
      i1_s2_r <= i1_s1_r;
      gp_s1_r <= pair_gpio_use;
      gp_s2_r <= gp_s1_r;
    end
  end

  // ==========================================================
  // outputs
  logic                       irq13_r;
  logic                       irq13_nxt;
  logic                       ignore_numeric_error_n_n_r;
  logic                       ignore_numeric_error_n_n_nxt;
  logic                       ad22_r;
  logic                       ad22_nxt;
  logic                       irq1_r;
  logic                       irq1_nxt;
  gcr_pkg::gcr_pair_mode_type mode_r;
  gcr_pkg::gcr_pair_mode_type mode_nxt;
  logic                       fpu_en;
  logic                       f0_wr;
  gcr_irq_if                  kirq ();

  assign fpu_en = gc_r[`GCR_BIT_FPU_EN];
  assign f0_wr  = io_wr && io_addr == `GCR_PORT_FPU_CLR;

  assign kirq.kbd_len   = gc_r[`GCR_BIT_KBD_LEN];
  assign kirq.irq1_sync = i1_s2_r;
  assign kirq.port60_rd = io_rd && io_addr == `GCR_PORT_KBD_DATA;

  gcr_kbd_latch u_kbd
  (
    .mclk (mclk),
    .rstn (rstn),
    .irq  (kirq)
  );

  always_comb
  begin
    irq13_nxt = irq13_r;
    if (f0_wr)
      irq13_nxt = 1'b0;
    if (fpu_en && !fe_s2_r)
      irq13_nxt = 1'b1; // see (R5)
    if (!fpu_en)
      irq13_nxt = 1'b0; // see (R7)
    ignore_numeric_error_n_n_nxt = !(fpu_en && !fe_s2_r); // see (R6) see (R7)
    ad22_nxt = ad22_req && !(gc_r[`GCR_BIT_HIDE] && cfg_cycle_to_bridge); // see (R4)
    if (gp_s2_r)
      mode_nxt = gcr_pkg::GCR_PAIR_GPIO; // see (R3)
    else if (gc_r[`GCR_BIT_PAIR_SEL])
      mode_nxt = gcr_pkg::GCR_PAIR_PCPCI; // see (R1)
    else
      mode_nxt = gcr_pkg::GCR_PAIR_PCI; // see (R2)
    irq1_nxt = kirq.irq1_out;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq13_r   <= 1'b0;
      ignore_numeric_error_n_n_r <= 1'b1;
      ad22_r    <= 1'b0;
      irq1_r    <= 1'b0;
      mode_r    <= gcr_pkg::GCR_PAIR_PCI;
    end
    else
    begin
      irq13_r   <= irq13_nxt;
      ignore_numeric_error_n_n_r <= ignore_numeric_error_n_n_nxt;
      ad22_r    <= ad22_nxt;
      irq1_r    <= irq1_nxt;
      mode_r    <= mode_nxt;
    end
  end

  assign irq13                  = irq13_r;
  assign ignore_numeric_error_n = ignore_numeric_error_n_n_r;
  assign ad22_drive             = ad22_r;
  assign irq1_out               = irq1_r;
  assign pair_mode              = mode_r;

  // ==========================================================
  // checks
  a_irq13_set: assert property (@(posedge mclk) disable iff (!rstn)
    fpu_en && !fe_s2_r |=> irq13 && !ignore_numeric_error_n) // see (R5) see (R6)
    else $error("fpu error not raised");
  a_irq13_hold: assert property (@(posedge mclk) disable iff (!rstn)
    irq13 && fpu_en && !f0_wr |=> irq13) // see (R5)
    else $error("irq13 dropped without port write");
  a_fpu_off: assert property (@(posedge mclk) disable iff (!rstn)
    !fpu_en |=> !irq13 && ignore_numeric_error_n) // see (R7)
    else $error("fpu error active while disabled");
  a_ad22_hide: assert property (@(posedge mclk) disable iff (!rstn)
    gc_r[`GCR_BIT_HIDE] && cfg_cycle_to_bridge |=> !ad22_drive) // see (R4)
    else $error("ad22 driven to hidden bridge");
  a_pair_mode: assert property (@(posedge mclk) disable iff (!rstn)
    !gp_s2_r |=> pair_mode == ($past(gc_r[`GCR_BIT_PAIR_SEL]) ?
      gcr_pkg::GCR_PAIR_PCPCI : gcr_pkg::GCR_PAIR_PCI)) // see (R1) see (R2)
    else $error("pair mode wrong");
  a_pair_gpio: assert property (@(posedge mclk) disable iff (!rstn)
    gp_s2_r |=> pair_mode == gcr_pkg::GCR_PAIR_GPIO) // see (R3)
    else $error("gpio override ignored");
  a_rsvd_zero: assert property (@(posedge mclk) disable iff (!rstn)
    cfg_rd |=> (cfg_rdata & ~`GCR_WMASK) == 32'h0000_0000) // see (R10)
    else $error("reserved bits nonzero");
  a_kbd_path: assert property (@(posedge mclk) disable iff (!rstn)
    !kirq.kbd_len |=> irq1_out == $past(i1_s2_r)) // see (R9)
    else $error("irq1 path wrong");
  a_irq13_clear: assert property (@(posedge mclk) disable iff (!rstn)
    irq13 && f0_wr && fe_s2_r |=> !irq13) // see (R5)
    else $error("irq13 not cleared by port write");
  a_ignore_numeric_error_n_follow: assert property (@(posedge mclk) disable iff (!rstn)
    fe_s2_r |=> ignore_numeric_error_n) // see (R6)
    else $error("ignore-numeric-error active without fpu error");
  a_ad22_pass: assert property (@(posedge mclk) disable iff (!rstn)
    !(gc_r[`GCR_BIT_HIDE] && cfg_cycle_to_bridge) |=> ad22_drive == $past(ad22_req)) // see (R4)
    else $error("ad22 request not passed");
  a_rsvd_write: assert property (@(posedge mclk) disable iff (!rstn)
    cfg_wr |=> (gc_r & ~`GCR_WMASK) == 32'h0000_0000) // see (R10)
    else $error("reserved bits written");
  a_rdata_hold: assert property (@(posedge mclk) disable iff (!rstn)
    !cfg_rd |=> $stable(cfg_rdata)) // see (R10)
    else $error("read data changed without read");
endmodule
`default_nettype wire

// ---- logic/gcr_irq_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface gcr_irq_if;
  logic kbd_len;
  logic irq1_sync;
  logic port60_rd;
  logic irq1_out;
  modport ctrl (output kbd_len, output irq1_sync, output port60_rd, input irq1_out);
  modport latch (input kbd_len, input irq1_sync, input port60_rd, output irq1_out);
endinterface
`default_nettype wire

// ---- logic/gcr_kbd_latch.sv ----
`timescale 1ns/1ps
`default_nettype none
module gcr_kbd_latch
(
  input  wire logic mclk,
  input  wire logic rstn,
  gcr_irq_if.latch  irq
);
  logic prev_r;
  logic prev_nxt;
  logic held_r;
  logic held_nxt;

  always_comb
  begin
    prev_nxt = irq.irq1_sync;
    held_nxt = held_r;
    if (irq.port60_rd)
      held_nxt = 1'b0;
    if (irq.irq1_sync && !prev_r)
      held_nxt = 1'b1; // see (R8)
    if (!irq.kbd_len)
      held_nxt = 1'b0;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      prev_r <= 1'b0;
      held_r <= 1'b0;
    end
    else
    begin
      prev_r <= prev_nxt;
      held_r <= held_nxt;
    end
  end

  // latch or bypass
  assign irq.irq1_out = irq.kbd_len ? held_r : irq.irq1_sync; // see (R8) see (R9)

  a_kbd_hold: assert property (@(posedge mclk) disable iff (!rstn)
    irq.kbd_len && held_r && !irq.port60_rd |=> held_r) // see (R8)
    else $error("latched keyboard request lost");
  a_kbd_edge: assert property (@(posedge mclk) disable iff (!rstn)
    irq.kbd_len && irq.irq1_sync && !prev_r |=> held_r) // see (R8)
    else $error("keyboard edge not latched");
  a_kbd_bypass: assert property (@(posedge mclk) disable iff (!rstn)
    !irq.kbd_len |=> !held_r) // see (R9)
    else $error("keyboard latch holds while bypassed");
endmodule
`default_nettype wire

// ---- logic/gcr_pkg.sv ----
package gcr_pkg;
  typedef enum logic [1:0] {
    GCR_PAIR_PCI,
    GCR_PAIR_PCPCI,
    GCR_PAIR_GPIO
  } gcr_pair_mode_type;
endpackage

// ---- testbench/gcr_general_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gcr_consts.svh"
module gcr_general_control_tb;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        cfg_wr = 1'b0, cfg_rd = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [3:0]  cfg_be = 4'hf;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, d;
  logic [15:0] io_addr = 16'h0000;
  logic        gpio = 1'b0, bridge = 1'b0, ad22_req = 1'b0, fpu_fault = 1'b0, kbd_key = 1'b0;
  logic        ad22_drive, fpu_n, irq1_in, irq13, ignore_numeric_error_n_n, irq1_out;
  gcr_pkg::gcr_pair_mode_type pair_mode;
  int          n_fail = 0, n_tests = 0, cycles = 0;
  always #10 mclk = ~mclk;
  gcr_pin_model pins (.mclk(mclk), .rstn(rstn), .fpu_fault(fpu_fault), .kbd_key(kbd_key),
    .fpu_error_in_n(fpu_n), .irq1_in(irq1_in));
  gcr_general_control uut (.mclk(mclk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .pair_gpio_use(gpio),
    .cfg_cycle_to_bridge(bridge), .ad22_req(ad22_req), .ad22_drive(ad22_drive),
    .pair_mode(pair_mode), .fpu_error_in_n(fpu_n), .irq1_in(irq1_in), .irq13(irq13),
    .ignore_numeric_error_n(ignore_numeric_error_n_n), .irq1_out(irq1_out));
  // ==========================================
  // tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error t=%0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cfg_write(input logic [7:0] a, input logic [31:0] w);
    @(posedge mclk) {cfg_wr, cfg_addr, cfg_wdata} <= {1'b1, a, w};
    @(posedge mclk) cfg_wr <= 1'b0;
  endtask
  task automatic cfg_read(input logic [7:0] a, output logic [31:0] r);
    @(posedge mclk) {cfg_rd, cfg_addr} <= {1'b1, a};
    @(posedge mclk) cfg_rd <= 1'b0;
    #1 r = cfg_rdata;
  endtask
  task automatic io(input logic w, input logic [15:0] a);
    @(posedge mclk) {io_wr, io_rd, io_addr} <= {w, ~w, a};
    @(posedge mclk) {io_wr, io_rd} <= 2'b00;
  endtask
  task automatic key();
    @(posedge mclk) kbd_key <= 1'b1;
    @(posedge mclk) kbd_key <= 1'b0;
  endtask
  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_fail++;
      summarize();
    end
  end
  // ==========================================
  // tests
  initial
  begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    cfg_read(`GCR_OFFSET, d);
    chk(d, `GCR_RESET);
    chk({ignore_numeric_error_n_n, irq13, irq1_out}, 32'h4);
    chk(32'(pair_mode), 32'(gcr_pkg::GCR_PAIR_PCI));
    cfg_write(`GCR_OFFSET, 32'hffff_ffff);
    cfg_read(`GCR_OFFSET, d);
    chk(d, `GCR_WMASK);
    cfg_read(8'hd4, d);
    chk(d, 32'h0);
    cfg_write(`GCR_OFFSET, 32'h0);
    cfg_be <= 4'h2;
    cfg_write(`GCR_OFFSET, 32'hffff_ffff);
    cfg_be <= 4'hf;
    cfg_read(`GCR_OFFSET, d);
    chk(d, 32'h0000_3000);
    $display("test register done");
    cfg_write(`GCR_OFFSET, 32'h0);
    cyc(2);
    chk(32'(pair_mode), 32'(gcr_pkg::GCR_PAIR_PCI));
    cfg_write(`GCR_OFFSET, 32'h0200_0000);
    cyc(2);
    chk(32'(pair_mode), 32'(gcr_pkg::GCR_PAIR_PCPCI));
    gpio <= 1'b1;
    cyc(5);
    chk(32'(pair_mode), 32'(gcr_pkg::GCR_PAIR_GPIO));
    {gpio, bridge, ad22_req} <= 3'b011;
    cfg_write(`GCR_OFFSET, 32'h0);
    cyc(2);
    chk(ad22_drive, 1'b1);
    cfg_write(`GCR_OFFSET, 32'h0100_0000);
    cyc(2);
    chk(ad22_drive, 1'b0);
    bridge <= 1'b0;
    cyc(2);
    chk(ad22_drive, 1'b1);
    $display("test pair and hide done");
    cfg_write(`GCR_OFFSET, 32'h0);
    fpu_fault <= 1'b1;
    cyc(6);
    chk({irq13, ignore_numeric_error_n_n}, 32'h1);
    cfg_write(`GCR_OFFSET, 32'h2000);
    cyc(5);
    chk({irq13, ignore_numeric_error_n_n}, 32'h2);
    fpu_fault <= 1'b0;
    cyc(6);
    chk(irq13, 1'b1);
    chk(ignore_numeric_error_n_n, 1'b1);
    io(1'b1, `GCR_PORT_FPU_CLR);
    cyc(2);
    chk(irq13, 1'b0);
    $display("test fpu done");
    cfg_write(`GCR_OFFSET, 32'h1000);
    key();
    cyc(5);
    chk(irq1_out, 1'b1);
    cyc(8);
    chk(irq1_out, 1'b1);
    io(1'b0, `GCR_PORT_KBD_DATA);
    cyc(2);
    chk(irq1_out, 1'b0);
    cfg_write(`GCR_OFFSET, 32'h0);
    key();
    cyc(5);
    chk(irq1_out, 1'b1);
    cyc(8);
    chk(irq1_out, 1'b0);
    $display("test keyboard done");
    cfg_write(`GCR_OFFSET, 32'hffff_ffff);
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cfg_read(`GCR_OFFSET, d);
    chk(d, `GCR_RESET);
    $display("test mid-run reset done");
    summarize();
  end
endmodule
`default_nettype wire

// ---- testbench/gcr_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module gcr_pin_model
(
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic fpu_fault,
  input  wire logic kbd_key,
  output logic      fpu_error_in_n,
  output logic      irq1_in
);
  logic [2:0] key_cnt_r;
  // ==========================================
  // pins
  // fpu pin active low, key press held four cycles
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      fpu_error_in_n <= 1'b1;
      key_cnt_r      <= 3'h0;
    end
    else
    begin
      fpu_error_in_n <= ~fpu_fault;
      key_cnt_r      <= kbd_key ? 3'h4 : ((key_cnt_r != 3'h0) ? key_cnt_r - 3'h1 : 3'h0);
    end
  end
  assign irq1_in = (key_cnt_r != 3'h0);
endmodule
`default_nettype wire
